// File: src/mrcs_defs.vh
// Constants for the memory run command status block: register offsets,
// status bit positions, event bit positions, state codes and reset values.
// Assumes inclusion by bare name from each design file that needs them.
`ifndef MRCS_DEFS_VH
`define MRCS_DEFS_VH

// APB byte offsets, one aligned 32-bit word each
`define MRCS_OFF_STATUS 12'h000
`define MRCS_OFF_IRQ_STAT 12'h004
`define MRCS_OFF_IRQ_MASK 12'h008
`define MRCS_OFF_CTRL 12'h00C
`define MRCS_ADDR_W 12

// Task command status word bit positions
`define MRCS_B_BUSY 0
`define MRCS_B_START_EN 1
`define MRCS_B_STOP_DECEL 4
`define MRCS_B_START_INV 8
`define MRCS_B_TEACH_INV 9
`define MRCS_B_STOP_EXEC 12
`define MRCS_B_RUN_DONE 13
`define MRCS_B_TEACH_DONE 14
`define MRCS_STAT_W 16

// Event vector layout, shared by the sticky flags and the interrupt status
`define MRCS_EV_W 5
`define MRCS_EV_START_INV 0
`define MRCS_EV_TEACH_INV 1
`define MRCS_EV_STOP_EXEC 2
`define MRCS_EV_RUN_DONE 3
`define MRCS_EV_TEACH_DONE 4

// Control register bit positions
`define MRCS_C_ENABLE 0
`define MRCS_CTRL_W 1

// Run state codes
`define MRCS_ST_W 2
`define MRCS_ST_IDLE 2'h0
`define MRCS_ST_RUN 2'h1
`define MRCS_ST_DECEL 2'h2

// Reset values
`define MRCS_RST_EV 5'h00
`define MRCS_RST_MASK 5'h00
`define MRCS_RST_CTRL 1'h1
`define MRCS_RST_WORD 32'h00000000

`endif

// File: src/mrcs_sticky.v
// Bank of sticky event flags with a per-bit clear.
// Assumes set and clear come from logic on the same clock; a set that
// lands in the cycle of its clear is kept.
`timescale 1ns/1ns
`include "mrcs_defs.vh"

module mrcs_sticky
(
  core_clk,
  rst,
  set_bits,
  clr_bits,
  flags
);
  input wire core_clk;
  input wire rst;
  input wire [`MRCS_EV_W-1:0] set_bits;
  input wire [`MRCS_EV_W-1:0] clr_bits;
  output wire [`MRCS_EV_W-1:0] flags;

  reg [`MRCS_EV_W-1:0] flags_ff;
  wire [`MRCS_EV_W-1:0] nxt_flags;

  // Set wins over clear so no event is lost on a racing clear
  assign nxt_flags = (flags_ff & ~clr_bits) | set_bits;

  // Flag storage
  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      flags_ff <= `MRCS_RST_EV;
    end
    else
    begin
      flags_ff <= nxt_flags;
    end
  end

  assign flags = flags_ff;
endmodule // mrcs_sticky

// File: src/mrcs_top.v
// Memory run command status: run/stop/teach sequencing for one task and
// the upper status word, with an APB slave and one level interrupt.
// Assumes all event and level inputs come from logic on core_clk.
//
// Decided for this implementation: the address map and the APB slave port.
`timescale 1ns/1ns
`include "mrcs_defs.vh"

module mrcs_top
(
  core_clk,
  rst,
  psel,
  penable,
  pwrite,
  paddr,
  pwdata,
  prdata,
  pready,
  pslverr,
  start_req,
  start_cmd_bad,
  stop_req,
  decel_done,
  error_stop,
  single_axis_stop,
  normal_end,
  teach_req,
  teach_done,
  axis_busy,
  func_busy,
  start_ack,
  teach_ack,
  run_active,
  status_word,
  irq
);
  input wire core_clk;
  input wire rst;
  input wire psel;
  input wire penable;
  input wire pwrite;
  input wire [`MRCS_ADDR_W-1:0] paddr;
  input wire [31:0] pwdata;
  output wire [31:0] prdata;
  output wire pready;
  output wire pslverr;
  input wire start_req;
  input wire start_cmd_bad;
  input wire stop_req;
  input wire decel_done;
  input wire error_stop;
  input wire single_axis_stop;
  input wire normal_end;
  input wire teach_req;
  input wire teach_done;
  input wire axis_busy;
  input wire func_busy;
  output wire start_ack;
  output wire teach_ack;
  output wire run_active;
  output wire [`MRCS_STAT_W-1:0] status_word;
  output wire irq;

  reg [`MRCS_ST_W-1:0] state_ff;
  reg [`MRCS_ST_W-1:0] nxt_state;
  reg teach_pend_ff;
  reg start_ack_ff;
  reg teach_ack_ff;
  reg [`MRCS_EV_W-1:0] mask_ff;
  reg [`MRCS_CTRL_W-1:0] ctrl_ff;
  reg [31:0] prdata_ff;
  reg pslverr_ff;
  reg [31:0] rd_word;
  reg rd_hit;
  reg [`MRCS_EV_W-1:0] ev_set;
  wire [`MRCS_EV_W-1:0] flag_bits;
  wire [`MRCS_EV_W-1:0] irq_bits;
  wire [`MRCS_EV_W-1:0] flag_clr;
  wire [`MRCS_EV_W-1:0] irq_clr;
  wire setup_phase;
  wire wr_take;
  wire start_enabled;
  wire busy;
  wire stop_decel;
  wire start_ok;
  wire start_bad;
  wire teach_ok;
  wire teach_bad;
  wire [`MRCS_STAT_W-1:0] stat_word;

  // Offset match for the register map, used by read and write decode
  function hit;
    input [`MRCS_ADDR_W-1:0] addr;
    input [`MRCS_ADDR_W-1:0] off;
    begin
      hit = (addr == off);
    end
  endfunction

  // Busy covers the run sequence, a pending teach and outside activity
  assign busy = (state_ff != `MRCS_ST_IDLE) | teach_pend_ff | axis_busy | func_busy;
  assign start_enabled = ~busy;
  assign stop_decel = (state_ff == `MRCS_ST_DECEL);

  // Start decisions; a start during stop deceleration is neither taken nor flagged
  assign start_ok = start_req & ~stop_decel & start_enabled & ~start_cmd_bad & ctrl_ff[`MRCS_C_ENABLE];
  assign start_bad = start_req & ~stop_decel & ~start_ok;

  // Teaching needs the task idle, like a start
  assign teach_ok = teach_req & start_enabled & ~start_req;
  assign teach_bad = teach_req & ~teach_ok;

  // Run sequence
  always @*
  begin
    nxt_state = state_ff;
    case (state_ff)
      `MRCS_ST_IDLE:
      begin
        if (start_ok)
        begin
          nxt_state = `MRCS_ST_RUN;
        end
      end
      `MRCS_ST_RUN:
      begin
        if (error_stop | single_axis_stop)
        begin
          nxt_state = `MRCS_ST_IDLE;
        end
        else if (stop_req)
        begin
          nxt_state = `MRCS_ST_DECEL;
        end
        else if (normal_end)
        begin
          nxt_state = `MRCS_ST_IDLE;
        end
      end
      `MRCS_ST_DECEL:
      begin
        if (decel_done | error_stop)
        begin
          nxt_state = `MRCS_ST_IDLE;
        end
      end
      default:
      begin
        nxt_state = `MRCS_ST_IDLE;
      end
    endcase
  end

  // Events raised by the sequence; normal end loses to any stop cause
  always @*
  begin
    ev_set = `MRCS_RST_EV;
    ev_set[`MRCS_EV_START_INV] = start_bad;
    ev_set[`MRCS_EV_TEACH_INV] = teach_bad;
    ev_set[`MRCS_EV_TEACH_DONE] = teach_pend_ff & teach_done;
    if (state_ff == `MRCS_ST_RUN)
    begin
      if (error_stop | single_axis_stop)
      begin
        ev_set[`MRCS_EV_STOP_EXEC] = 1'b1;
      end
      else if (normal_end & ~stop_req)
      begin
        ev_set[`MRCS_EV_RUN_DONE] = 1'b1;
      end
    end
    else if (state_ff == `MRCS_ST_DECEL)
    begin
      if (decel_done | error_stop)
      begin
        ev_set[`MRCS_EV_STOP_EXEC] = 1'b1;
      end
    end
  end

  // Sequence registers and acknowledges
  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      state_ff <= `MRCS_ST_IDLE;
      teach_pend_ff <= 1'b0;
      start_ack_ff <= 1'b0;
      teach_ack_ff <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      start_ack_ff <= start_ok;
      teach_ack_ff <= teach_ok;
      if (teach_ok)
      begin
        teach_pend_ff <= 1'b1;
      end
      else if (teach_done)
      begin
        teach_pend_ff <= 1'b0;
      end
    end
  end

  // Status flags clear when the matching command is accepted again
  assign flag_clr[`MRCS_EV_START_INV] = start_ok;
  assign flag_clr[`MRCS_EV_STOP_EXEC] = start_ok;
  assign flag_clr[`MRCS_EV_RUN_DONE] = start_ok;
  assign flag_clr[`MRCS_EV_TEACH_INV] = teach_ok;
  assign flag_clr[`MRCS_EV_TEACH_DONE] = teach_ok;

  mrcs_sticky u_flags
  (
    .core_clk(core_clk),
    .rst(rst),
    .set_bits(ev_set),
    .clr_bits(flag_clr),
    .flags(flag_bits)
  );

  // APB phases; zero wait states, so every access ends in its first access cycle
  assign setup_phase = psel & ~penable;
  assign wr_take = psel & penable & pwrite;
  assign irq_clr = (wr_take & hit(paddr, `MRCS_OFF_IRQ_STAT)) ? pwdata[`MRCS_EV_W-1:0] : `MRCS_RST_EV;

  mrcs_sticky u_irq
  (
    .core_clk(core_clk),
    .rst(rst),
    .set_bits(ev_set),
    .clr_bits(irq_clr),
    .flags(irq_bits)
  );

  // Assemble the task command status word; unused bits read zero
  assign stat_word = {
    1'b0,
    flag_bits[`MRCS_EV_TEACH_DONE],
    flag_bits[`MRCS_EV_RUN_DONE],
    flag_bits[`MRCS_EV_STOP_EXEC],
    2'h0,
    flag_bits[`MRCS_EV_TEACH_INV],
    flag_bits[`MRCS_EV_START_INV],
    3'h0,
    stop_decel,
    2'h0,
    start_enabled,
    busy
  };

  // Read mux; unmapped offsets answer with an error and zero data
  always @*
  begin
    rd_word = `MRCS_RST_WORD;
    rd_hit = 1'b1;
    if (hit(paddr, `MRCS_OFF_STATUS))
    begin
      rd_word[`MRCS_STAT_W-1:0] = stat_word;
    end
    else if (hit(paddr, `MRCS_OFF_IRQ_STAT))
    begin
      rd_word[`MRCS_EV_W-1:0] = irq_bits;
    end
    else if (hit(paddr, `MRCS_OFF_IRQ_MASK))
    begin
      rd_word[`MRCS_EV_W-1:0] = mask_ff;
    end
    else if (hit(paddr, `MRCS_OFF_CTRL))
    begin
      rd_word[`MRCS_CTRL_W-1:0] = ctrl_ff;
    end
    else
    begin
      rd_hit = 1'b0;
    end
  end

  // Read data and error are captured in setup, so they come from flops in access
  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      prdata_ff <= `MRCS_RST_WORD;
      pslverr_ff <= 1'b0;
    end
    else if (setup_phase)
    begin
      prdata_ff <= pwrite ? `MRCS_RST_WORD : rd_word;
      pslverr_ff <= ~rd_hit;
    end
  end

  // Writable registers; the status word itself is read only
  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      mask_ff <= `MRCS_RST_MASK;
      ctrl_ff <= `MRCS_RST_CTRL;
    end
    else if (wr_take)
    begin
      if (hit(paddr, `MRCS_OFF_IRQ_MASK))
      begin
        mask_ff <= pwdata[`MRCS_EV_W-1:0];
      end
      if (hit(paddr, `MRCS_OFF_CTRL))
      begin
        ctrl_ff <= pwdata[`MRCS_CTRL_W-1:0];
      end
    end
  end

  assign prdata = prdata_ff;
  assign pready = 1'b1;
  assign pslverr = pslverr_ff & psel & penable;
  assign irq = |(irq_bits & mask_ff);
  assign start_ack = start_ack_ff;
  assign teach_ack = teach_ack_ff;
  assign run_active = (state_ff != `MRCS_ST_IDLE);
  assign status_word = stat_word;
endmodule // mrcs_top

// File: tb/memory_run_command_status_tb.sv
// Testbench for the status block: commands, flags, registers, interrupt.
// Assumes the host model as APB master and a 100 MHz clock.
`timescale 1ns/1ns

module memory_run_command_status_tb;
  logic core_clk, rst, go, wr, psel, penable, pwrite, pready, pslverr, done, err;
  logic bad, axis_busy, func_busy, start_ack, teach_ack, run_active, irq;
  logic [11:0] addr, paddr;
  logic [31:0] wdata, pwdata, prdata, rdata;
  logic [7:0] cmd; // start stop decel error single normal teach teach_done
  logic [15:0] sw;
  int mismatches, samples_checked;

  mrcs_host_model i_host (.core_clk(core_clk), .rst(rst), .go(go), .wr(wr), .addr(addr), .wdata(wdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .done(done), .rdata(rdata), .err(err));
  mrcs_top i_dut (.core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .start_req(cmd[0]),
    .start_cmd_bad(bad), .stop_req(cmd[1]), .decel_done(cmd[2]), .error_stop(cmd[3]),
    .single_axis_stop(cmd[4]), .normal_end(cmd[5]), .teach_req(cmd[6]), .teach_done(cmd[7]),
    .axis_busy(axis_busy), .func_busy(func_busy), .start_ack(start_ack), .teach_ack(teach_ack),
    .run_active(run_active), .status_word(sw), .irq(irq));

  // Clock generator
  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  task chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      mismatches++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask

  // One bus transfer, waiting on the model's done under a bound
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    go <= 1'b1;
    wr <= w;
    addr <= a;
    wdata <= d;
    do
      @(posedge core_clk);
    while (done !== 1'b1 && ++n < 50);
    if (n >= 50) chk(1'b0, 1'b1);
    go <= 1'b0;
  endtask

  // One-cycle command pulse; outputs are settled on return
  task pulse(input int i);
    @(posedge core_clk);
    cmd <= 8'h01 << i;
    @(posedge core_clk);
    cmd <= 8'h00;
    #1;
  endtask

  task t_regs;
    apb(0, 12'h000, 0); chk(rdata, 32'h00000002);
    apb(0, 12'h008, 0); chk(rdata, 32'h00000000);
    apb(0, 12'h00C, 0); chk(rdata, 32'h00000001);
    apb(0, 12'h010, 0); chk({rdata[30:0], err}, 32'h00000001);
    apb(1, 12'h000, 32'hFFFFFFFF); apb(0, 12'h000, 0); chk(rdata, 32'h00000002);
  endtask

  task t_stop;
    pulse(0); chk(start_ack, 1); chk(sw, 16'h0001);
    chk(run_active, 1);
    pulse(1); chk(sw, 16'h0011);
    pulse(0); chk(start_ack, 0); chk(sw, 16'h0011);
    pulse(2); chk(sw, 16'h1002);
    chk(run_active, 0);
    apb(1, 12'h008, 32'h00000004); #1 chk(irq, 1);
    apb(1, 12'h004, 32'h00000004); #1 chk(irq, 0);
  endtask

  task t_ends;
    for (int i = 3; i < 6; i++)
    begin
      pulse(0); pulse(i); chk(sw, i == 5 ? 16'h2002 : 16'h1002);
    end
  endtask

  task t_bad;
    bad <= 1'b1; pulse(0); chk(start_ack, 0); chk(sw, 16'h2102);
    bad <= 1'b0; pulse(0); chk(sw, 16'h0001);
    pulse(0); chk(start_ack, 0); chk(sw, 16'h0101);
    pulse(5); apb(1, 12'h00C, 0); pulse(0); chk(start_ack, 0);
    apb(1, 12'h00C, 1);
  endtask

  task t_teach;
    pulse(6); chk(teach_ack, 1); chk(sw[0], 1);
    pulse(7); chk(sw[14], 1); chk(sw[0], 0);
    // Start invalid flag from the disabled start above is still sticky here
    axis_busy <= 1'b1; pulse(6); chk(teach_ack, 0); chk(sw[9:0], 10'h301);
    axis_busy <= 1'b0;
    // A running task function alone must also block a start
    func_busy <= 1'b1; pulse(0); chk(start_ack, 0);
    chk(sw[1:0], 2'h1);
    func_busy <= 1'b0;
  endtask

  task stop_test;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Main sequence
  initial
  begin
    {rst, go, wr, bad, axis_busy, func_busy, cmd, addr, wdata} = '0;
    mismatches = 0;
    samples_checked = 0;
    rst = 1'b1;
    repeat (16) @(posedge core_clk);
    rst <= 1'b0;
    t_regs;
    t_stop;
    t_ends;
    t_bad;
    t_teach;
    stop_test;
  end

  // Watchdog
  initial
  begin
    #200000;
    mismatches++;
    stop_test;
  end
endmodule // memory_run_command_status_tb

// File: tb/mrcs_host_model.sv
// Host side APB master model for the status block.
// Assumes one request at a time, raised with go and held until done.
`timescale 1ns/1ns

module mrcs_host_model
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic go,
  input wire logic wr,
  input wire logic [11:0] addr,
  input wire logic [31:0] wdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata,
  output logic done,
  output logic [31:0] rdata,
  output logic err
);
  // Setup, then access until pready; address and data are inverted once released
  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      psel <= 1'b0;
      penable <= 1'b0;
      done <= 1'b0;
    end
    else
    begin
      done <= 1'b0;
      if (psel && penable && pready)
      begin
        psel <= 1'b0;
        penable <= 1'b0;
        done <= 1'b1;
        rdata <= prdata;
        err <= pslverr;
        paddr <= ~paddr; // Stale values must not look valid
        pwdata <= ~pwdata;
      end
      else if (psel)
        penable <= 1'b1;
      else if (go && !done)
      begin
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= wdata;
      end
    end
  end
endmodule // mrcs_host_model

// File: tb/mrcs_top_assertions.sv
// Checker for the status block, bound to the top module's ports.
// Assumes a single clock domain with an asynchronous high reset.
`timescale 1ns/1ns

module mrcs_chk
(
  input wire core_clk,
  input wire rst,
  input wire start_req,
  input wire start_cmd_bad,
  input wire stop_req,
  input wire decel_done,
  input wire error_stop,
  input wire single_axis_stop,
  input wire normal_end,
  input wire teach_req,
  input wire teach_done,
  input wire axis_busy,
  input wire start_ack,
  input wire teach_ack,
  input wire run_active,
  input wire [15:0] status_word
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  wire run = run_active && !status_word[4];
  wire hard = error_stop || single_axis_stop;
  // Command to flag relations, one cycle apart, except the same-cycle busy bits check
  AST_DECEL_ENTER: assert property (run && stop_req && !hard |=> status_word[4]) else $error("no decel");
  AST_DECEL_HOLD: assert property (status_word[4] && !decel_done && !error_stop |=> status_word[4])
    else $error("decel dropped");
  AST_DECEL_NO_ACK: assert property (status_word[4] && start_req |=> !start_ack) else $error("ack in decel");
  AST_START_INV: assert property (!status_word[4] && start_req && start_cmd_bad |=> status_word[8] && !start_ack)
    else $error("bad start taken");
  AST_STOP_EXEC: assert property ((status_word[4] && decel_done) || (run && hard) |=> status_word[12])
    else $error("no stop flag");
  AST_RUN_DONE: assert property (run && normal_end && !stop_req && !hard |=> status_word[13])
    else $error("no done flag");
  AST_DONE_CAUSE: assert property ($rose(status_word[13]) |-> $past(normal_end)) else $error("done uncaused");
  AST_TEACH_DONE: assert property ($rose(status_word[14]) |-> $past(teach_done)) else $error("teach uncaused");
  AST_BUSY: assert property (axis_busy |-> status_word[0] && !status_word[1]) else $error("busy bits");
  AST_TEACH_INV: assert property (teach_req && !status_word[1] |=> status_word[9] && !teach_ack)
    else $error("teach taken busy");
endmodule // mrcs_chk

bind mrcs_top mrcs_chk i_chk (.core_clk(core_clk), .rst(rst), .start_req(start_req), .start_cmd_bad(start_cmd_bad),
  .stop_req(stop_req), .decel_done(decel_done), .error_stop(error_stop), .single_axis_stop(single_axis_stop),
  .normal_end(normal_end), .teach_req(teach_req), .teach_done(teach_done), .axis_busy(axis_busy),
  .start_ack(start_ack), .teach_ack(teach_ack), .run_active(run_active), .status_word(status_word));
